// ===== src/fpc_defines.vh
// Register offsets, field positions, key values and timing counts for the flash program control block.
`ifndef FPC_DEFINES_VH
`define FPC_DEFINES_VH
// ************************************************************
// Register word addresses (byte address = 4 * index)
// ************************************************************
`define FPC_IDX_FLASH_CTRL_ONE 4'h0
`define FPC_IDX_FLASH_CTRL_COMMIT 4'h1
`define FPC_IDX_FLASH_STATUS_REG 4'h2
`define FPC_IDX_SYS_CTRL_TWO 4'h3
`define FPC_IDX_SYS_CTRL_THREE 4'h4
`define FPC_IDX_SYS_CTRL_COMMIT 4'h5
`define FPC_IDX_CMD_DATA 4'h6
`define FPC_IDX_IRQ_STATUS 4'h7
`define FPC_IDX_IRQ_MASK 4'h8
`define FPC_IDX_ACTIVE 4'h9
// ************************************************************
// Field positions and values
// ************************************************************
`define FPC_MODE_HI 7
`define FPC_MODE_LO 5
`define FPC_AREA_HI 4
`define FPC_AREA_LO 3
`define FPC_MODE_ENABLE 3'h5
`define FPC_MODE_DISABLE 3'h2
`define FPC_AREA_INIT 2'h0
`define FPC_FLASH_KEY 8'hD5
`define FPC_SYS_KEY 8'hD4
`define FPC_SYSRST_VAL 8'h10
`define FPC_RAM_CODE_ALLOC_BIT 2
`define FPC_VECTOR_TO_RAM_BIT 1
`define FPC_BUSY_BIT 7
`define FPC_CTRL_ONE_RST 8'h40
`define FPC_SYS_CTRL_THREE_RST 8'h00
// ************************************************************
// Command bytes
// ************************************************************
`define FPC_CMD_AA 8'hAA
`define FPC_CMD_55 8'h55
`define FPC_CMD_80 8'h80
`define FPC_CMD_30 8'h30
`define FPC_CMD_A0 8'hA0
`define FPC_PAGE_BYTES 8'h80
// ************************************************************
// Timing
// ************************************************************
`define FPC_ERASE_CYCLES 32'h0000_0FA0
`define FPC_WRITE_CYCLES 32'h0000_07D0
`endif

// ===== src/fpc_flash_program_control.v
// Flash program control: keyed command mode, command sequence tracking, busy flag and RAM code mapping.
//
// Behaviour
// (RULE1) Software spaces command byte writes at least four machine cycles apart, as bytes.
// (RULE2) Software waits three machine cycles after the last command write before reading busy.
// (RULE3) Mode and area settings take effect only when the flash commit key is written.
// (RULE4) Busy reads one during erase or write and clears when the operation finishes.
// (RULE5) Committing disable mode with initial area stops sequences and restores area mapping.
// (RULE6) Both RAM bits set then system key maps RAM to code and vectors.
// (RULE7) Both RAM bits clear then system key returns code and vectors to flash.
// (RULE8) Software places the nonmaskable vectors in RAM before writing flash from RAM.
// (RULE9) Software never enables RAM code allocation while running in the affected flash range.
// (RULE10) Writing the reset value to system control two raises a system clock reset.
// (RULE11) Software polls the same flash address until busy reads zero.
// (RULE12) Sector erase is six byte writes ending with the erase byte.
// (RULE13) Page write is three command bytes followed by 128 data bytes.
// (RULE14) Any commit value other than the exact key leaves the active settings unchanged.
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "fpc_defines.vh"
module fpc_flash_program_control #(
   parameter ERASE_CYCLES = `FPC_ERASE_CYCLES,
   parameter WRITE_CYCLES = `FPC_WRITE_CYCLES
) (
   input wire clk,
   input wire reset,
   input wire [5:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   output reg irq,
   output reg cmd_enabled,
   output reg [1:0] area_active,
   output reg ram_code_alloc_active,
   output reg vector_to_ram_active,
   output reg sys_clk_reset
);
   // ************************************************************
   // States
   // ************************************************************
   localparam ST_IDLE = 3'h0;
   localparam ST_C1 = 3'h1;
   localparam ST_C2 = 3'h2;
   localparam ST_C3 = 3'h3;
   localparam ST_C4 = 3'h4;
   localparam ST_C5 = 3'h5;
   localparam ST_PAGE = 3'h6;
   localparam ST_BUSY = 3'h7;

   reg [7:0] flash_ctrl_one_q;
   reg [7:0] sys_ctrl_three_q;
   reg [2:0] state_q;
   reg [7:0] page_cnt_q;
   reg [31:0] op_cnt_q;
   reg op_is_erase_q;
   wire [1:0] irq_status_q;
   reg [1:0] irq_mask_q;
   reg ack_q;
   reg [31:0] rdata_d;
   reg seq_error_d;

   wire access = (avs_read | avs_write) & ~ack_q;
   // Only byte lane 0 carries register data; a write without it is dropped.
   wire wr = avs_write & ~ack_q & avs_byteenable[0];
   wire [3:0] idx = avs_address[5:2];
   wire [7:0] wbyte = avs_writedata[7:0];
   wire busy = (state_q == ST_BUSY);
   wire cmd_wr = wr & (idx == `FPC_IDX_CMD_DATA) & cmd_enabled;
   wire op_done = busy & (op_cnt_q == 32'h0000_0000);
   wire [1:0] irq_set = {seq_error_d, op_done};
   wire flash_commit = wr & (idx == `FPC_IDX_FLASH_CTRL_COMMIT) & (wbyte == `FPC_FLASH_KEY); // see (RULE14)
   wire sys_commit = wr & (idx == `FPC_IDX_SYS_CTRL_COMMIT) & (wbyte == `FPC_SYS_KEY); // see (RULE14)

   // ************************************************************
   // Avalon slave: one wait cycle, answer on the second edge
   // ************************************************************
   always @(posedge clk) begin
      if (reset) begin
         ack_q <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         ack_q <= access;
         avs_waitrequest <= ~access;
         avs_readdata <= rdata_d;
      end
   end

   always @* begin
      rdata_d = 32'h0000_0000;
      if (avs_read & ~ack_q) begin
         if (idx == `FPC_IDX_FLASH_CTRL_ONE) begin
            rdata_d[7:0] = flash_ctrl_one_q;
         end else if (idx == `FPC_IDX_FLASH_STATUS_REG) begin
            rdata_d[`FPC_BUSY_BIT] = busy; // see (RULE4)
            // Bit 0 tells software whether the last operation was an erase or a page write.
            rdata_d[0] = op_is_erase_q;
         end else if (idx == `FPC_IDX_SYS_CTRL_THREE) begin
            rdata_d[7:0] = sys_ctrl_three_q;
         end else if (idx == `FPC_IDX_IRQ_STATUS) begin
            rdata_d[1:0] = irq_status_q;
         end else if (idx == `FPC_IDX_IRQ_MASK) begin
            rdata_d[1:0] = irq_mask_q;
         end else if (idx == `FPC_IDX_ACTIVE) begin
            rdata_d[4:0] = {cmd_enabled, area_active, ram_code_alloc_active, vector_to_ram_active};
         end else begin
            rdata_d = 32'h0000_0000;
         end
      end
   end

   // ************************************************************
   // Staged and active configuration
   // ************************************************************
   always @(posedge clk) begin
      if (reset) begin
         flash_ctrl_one_q <= `FPC_CTRL_ONE_RST;
         sys_ctrl_three_q <= `FPC_SYS_CTRL_THREE_RST;
         cmd_enabled <= 1'b0;
         area_active <= `FPC_AREA_INIT;
         ram_code_alloc_active <= 1'b0;
         vector_to_ram_active <= 1'b0;
         sys_clk_reset <= 1'b0;
      end else begin
         sys_clk_reset <= wr & (idx == `FPC_IDX_SYS_CTRL_TWO) & (wbyte == `FPC_SYSRST_VAL); // see (RULE10)
         if (wr & (idx == `FPC_IDX_FLASH_CTRL_ONE)) begin
            flash_ctrl_one_q <= wbyte;
         end
         if (wr & (idx == `FPC_IDX_SYS_CTRL_THREE)) begin
            sys_ctrl_three_q <= wbyte;
         end
         if (flash_commit) begin // see (RULE3)
            if (flash_ctrl_one_q[`FPC_MODE_HI:`FPC_MODE_LO] == `FPC_MODE_ENABLE) begin
               cmd_enabled <= 1'b1;
               area_active <= flash_ctrl_one_q[`FPC_AREA_HI:`FPC_AREA_LO];
            end else if (flash_ctrl_one_q[`FPC_MODE_HI:`FPC_MODE_LO] == `FPC_MODE_DISABLE) begin // see (RULE5)
               cmd_enabled <= 1'b0;
               area_active <= `FPC_AREA_INIT;
            end
         end
         // Mixed RAM bits under the system key leave the mapping as it was.
         if (sys_commit) begin
            if (sys_ctrl_three_q[`FPC_RAM_CODE_ALLOC_BIT] & sys_ctrl_three_q[`FPC_VECTOR_TO_RAM_BIT]) begin // see (RULE6)
               ram_code_alloc_active <= 1'b1;
               vector_to_ram_active <= 1'b1;
            end else if (~sys_ctrl_three_q[`FPC_RAM_CODE_ALLOC_BIT] & ~sys_ctrl_three_q[`FPC_VECTOR_TO_RAM_BIT]) begin // see (RULE7)
               ram_code_alloc_active <= 1'b0;
               vector_to_ram_active <= 1'b0;
            end
         end
      end
   end

   // ************************************************************
   // Command sequence tracker
   // ************************************************************
   // A wrong byte in any state from ST_IDLE to ST_C5 drops the tracker back to idle rather than locking it.
   always @(posedge clk) begin
      if (reset) begin
         state_q <= ST_IDLE;
         page_cnt_q <= 8'h00;
         op_cnt_q <= 32'h0000_0000;
         op_is_erase_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (cmd_wr) begin
                  state_q <= (wbyte == `FPC_CMD_AA) ? ST_C1 : ST_IDLE;
               end
            end
            ST_C1: begin
               if (cmd_wr) begin
                  state_q <= (wbyte == `FPC_CMD_55) ? ST_C2 : ST_IDLE;
               end
            end
            ST_C2: begin
               if (cmd_wr) begin
                  if (wbyte == `FPC_CMD_80) begin // see (RULE12)
                     state_q <= ST_C3;
                  end else if (wbyte == `FPC_CMD_A0) begin // see (RULE13)
                     state_q <= ST_PAGE;
                     page_cnt_q <= 8'h00;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_C3: begin
               if (cmd_wr) begin
                  state_q <= (wbyte == `FPC_CMD_AA) ? ST_C4 : ST_IDLE;
               end
            end
            ST_C4: begin
               if (cmd_wr) begin
                  state_q <= (wbyte == `FPC_CMD_55) ? ST_C5 : ST_IDLE;
               end
            end
            ST_C5: begin
               if (cmd_wr) begin
                  if (wbyte == `FPC_CMD_30) begin // see (RULE12)
                     state_q <= ST_BUSY;
                     op_is_erase_q <= 1'b1;
                     op_cnt_q <= ERASE_CYCLES;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_PAGE: begin
               if (cmd_wr) begin
                  page_cnt_q <= page_cnt_q + 8'h01;
                  if (page_cnt_q == (`FPC_PAGE_BYTES - 8'h01)) begin // see (RULE13)
                     state_q <= ST_BUSY;
                     op_is_erase_q <= 1'b0;
                     op_cnt_q <= WRITE_CYCLES;
                  end
               end
            end
            ST_BUSY: begin
               // Busy lasts one cycle beyond the count, so even a zero count shows busy once.
               if (op_cnt_q == 32'h0000_0000) begin // see (RULE4)
                  state_q <= ST_IDLE;
               end else begin
                  op_cnt_q <= op_cnt_q - 32'h0000_0001;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Lost command bytes
   // ************************************************************
   // A byte the tracker cannot use, or one sent while busy, is flagged so software can restart the sequence.
   always @* begin
      seq_error_d = 1'b0;
      if (cmd_wr) begin
         case (state_q)
            ST_IDLE: begin
               seq_error_d = (wbyte != `FPC_CMD_AA);
            end
            ST_C1: begin
               seq_error_d = (wbyte != `FPC_CMD_55);
            end
            ST_C2: begin
               seq_error_d = (wbyte != `FPC_CMD_80) & (wbyte != `FPC_CMD_A0);
            end
            ST_C3: begin
               seq_error_d = (wbyte != `FPC_CMD_AA);
            end
            ST_C4: begin
               seq_error_d = (wbyte != `FPC_CMD_55);
            end
            ST_C5: begin
               seq_error_d = (wbyte != `FPC_CMD_30);
            end
            ST_PAGE: begin
               seq_error_d = 1'b0;
            end
            default: begin
               seq_error_d = 1'b1;
            end
         endcase
      end
   end

   // ************************************************************
   // Interrupts: bit 0 operation done, bit 1 command byte lost
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_irq_bit
         reg flag_q;
         assign irq_status_q[gi] = flag_q;
         always @(posedge clk) begin
            if (reset) begin
               flag_q <= 1'b0;
            end else if (irq_set[gi]) begin
               // Set wins over a write-one clear in the same cycle.
               flag_q <= 1'b1;
            end else if (wr & (idx == `FPC_IDX_IRQ_STATUS) & avs_writedata[gi]) begin
               flag_q <= 1'b0;
            end
         end
      end
   endgenerate

   always @(posedge clk) begin
      if (reset) begin
         irq_mask_q <= 2'h0;
         irq <= 1'b0;
      end else begin
         if (wr & (idx == `FPC_IDX_IRQ_MASK)) begin
            irq_mask_q <= avs_writedata[1:0];
         end
         irq <= |(irq_status_q & irq_mask_q);
      end
   end
endmodule // fpc_flash_program_control

// ===== verif/fpc_monitor.sv
// Port assertions for the flash program control block.
`timescale 1ns/1ps
module fpc_monitor (
   input wire clk,
   input wire reset,
   input wire [5:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   input wire irq,
   input wire cmd_enabled,
   input wire [1:0] area_active,
   input wire ram_code_alloc_active,
   input wire vector_to_ram_active,
   input wire sys_clk_reset
);
   wire tk = avs_write && avs_waitrequest && avs_byteenable[0];
   wire [3:0] idx = avs_address[5:2];
   wire [7:0] wd = avs_writedata[7:0];
   reg [7:0] ctl_q;
   reg [1:0] ram_q;
   // Shadow copies of the staged settings, so commits can be judged.
   always @(posedge clk) begin
      if (reset) begin
         ctl_q <= 8'h40;
         ram_q <= 2'h0;
      end else if (tk && idx == 4'h0) begin
         ctl_q <= wd;
      end else if (tk && idx == 4'h4) begin
         ram_q <= wd[2:1];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer held too long");
   a_flash_enable: assert property (tk && idx == 4'h1 && wd == 8'hD5 && ctl_q[7:5] == 3'h5 |=>
      cmd_enabled && area_active == $past(ctl_q[4:3])) else $error("enable commit ignored");
   a_flash_disable: assert property (tk && idx == 4'h1 && wd == 8'hD5 && ctl_q[7:3] == 5'h08 |=>
      !cmd_enabled && area_active == 2'h0) else $error("disable commit ignored");
   a_flash_badkey: assert property (tk && idx == 4'h1 && wd != 8'hD5 |=>
      $stable(cmd_enabled) && $stable(area_active)) else $error("bad flash key took effect");
   a_map_ram: assert property (tk && idx == 4'h5 && wd == 8'hD4 && ram_q == 2'h3 |=>
      ram_code_alloc_active && vector_to_ram_active) else $error("ram mapping not applied");
   a_map_flash: assert property (tk && idx == 4'h5 && wd == 8'hD4 && ram_q == 2'h0 |=>
      !ram_code_alloc_active && !vector_to_ram_active) else $error("flash mapping not restored");
   a_map_badkey: assert property (tk && idx == 4'h5 && wd != 8'hD4 |=>
      $stable(ram_code_alloc_active) && $stable(vector_to_ram_active)) else $error("bad system key took effect");
   a_map_mixed: assert property (tk && idx == 4'h5 && wd == 8'hD4 && ram_q[0] != ram_q[1] |=>
      $stable(ram_code_alloc_active) && $stable(vector_to_ram_active)) else $error("mixed bits changed mapping");
   a_sysrst_cause: assert property ($rose(sys_clk_reset) |-> $past(tk && idx == 4'h3 && wd == 8'h10))
      else $error("system clock reset without request");
   a_sysrst_pulse: assert property (tk && idx == 4'h3 && wd == 8'h10 |->
      ##[1:2] (sys_clk_reset ##1 !sys_clk_reset)) else $error("no system clock reset pulse");
endmodule // fpc_monitor
bind fpc_flash_program_control fpc_monitor u_fpc_monitor (.clk(clk), .reset(reset), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .cmd_enabled(cmd_enabled),
   .area_active(area_active), .ram_code_alloc_active(ram_code_alloc_active),
   .vector_to_ram_active(vector_to_ram_active), .sys_clk_reset(sys_clk_reset));

// ===== verif/fpc_cpu_model.sv
// Bus master model of the CPU running the flash control program from RAM.
`timescale 1ns/1ps
module fpc_cpu_model (
   input wire clk,
   output reg [5:0] avs_address,
   output reg avs_read,
   output reg avs_write,
   output reg [31:0] avs_writedata,
   output reg [3:0] avs_byteenable,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest
);
   // Byte lanes of the next request; only lane 0 is a legal byte write.
   reg [3:0] lanes = 4'h1;
   // Addresses of the trap vectors that the RAM control program keeps for nonmaskable interrupts.
   reg [19:0] vec_addr [0:1];
   task place_vectors;
      begin
         vec_addr[0] = 20'h001F8;
         vec_addr[1] = 20'h001FC;
      end
   endtask
   initial begin
      avs_address = 6'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h1;
   end
   task xfer(input rd, input [3:0] i, input [7:0] d, output [7:0] q);
      begin
         avs_address <= {i, 2'h0};
         avs_writedata <= {24'h0, d};
         avs_byteenable <= lanes;
         avs_read <= rd;
         avs_write <= !rd;
         @(posedge clk);
         while (avs_waitrequest) @(posedge clk);
         q = avs_readdata[7:0];
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         avs_writedata <= ~avs_writedata;
         // Idle gap keeps command bytes four cycles apart and delays the busy read.
         repeat (2) @(posedge clk);
      end
   endtask
   task poll(output [7:0] q);
      integer k;
      begin
         q = 8'hFF;
         for (k = 0; k < 100 && q[7]; k = k + 1) xfer(1'b1, 4'h2, 8'h0, q);
      end
   endtask
endmodule // fpc_cpu_model

// ===== verif/tb_top.sv
// Self-checking testbench for the flash program control block.
`timescale 1ns/1ps
module tb_top;
   reg clk = 1'b0;
   reg reset = 1'b1;
   wire [5:0] avs_address;
   wire avs_read, avs_write, avs_waitrequest, irq, cmd_enabled, ram_on, vec_on, sys_clk_reset;
   wire [31:0] avs_writedata, avs_readdata;
   wire [3:0] avs_byteenable;
   wire [1:0] area_active;
   integer err_count = 0;
   integer compares = 0;
   integer pulses = 0;
   integer n;
   reg [7:0] q;
   initial forever #2 clk = ~clk;
   always @(posedge clk) if (sys_clk_reset === 1'b1) pulses <= pulses + 1;
   fpc_flash_program_control #(.ERASE_CYCLES(20), .WRITE_CYCLES(20)) u_fpc_flash_program_control (.clk(clk),
      .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq), .cmd_enabled(cmd_enabled), .area_active(area_active),
      .ram_code_alloc_active(ram_on), .vector_to_ram_active(vec_on), .sys_clk_reset(sys_clk_reset));
   fpc_cpu_model u_fpc_cpu_model (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   task chk_reg(input [7:0] got, input [7:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
         end
      end
   endtask
   task chk_pin(input got, input exp);
      chk_reg({7'h0, got}, {7'h0, exp});
   endtask
   task wr(input [3:0] i, input [7:0] d);
      u_fpc_cpu_model.xfer(1'b0, i, d, q);
   endtask
   task rd(input [3:0] i);
      u_fpc_cpu_model.xfer(1'b1, i, 8'h0, q);
   endtask
   task erase_seq;
      for (n = 0; n < 6; n = n + 1) begin
         wr(4'h6, n % 3 == 1 ? 8'h55 : n == 2 ? 8'h80 : n == 5 ? 8'h30 : 8'hAA);
      end
   endtask
   task t_key;
      begin
         rd(4'h0);
         chk_reg(q, 8'h40);
         rd(4'hF);
         chk_reg(q, 8'h0);
         wr(4'h0, 8'hB0);
         wr(4'h1, 8'h5A);
         chk_pin(cmd_enabled, 1'b0);
         wr(4'h1, 8'hD5);
         chk_pin(cmd_enabled, 1'b1);
         chk_reg(area_active, 8'h2);
         rd(4'h9);
         chk_reg(q, 8'h18);
         wr(4'h0, 8'hE8);
         wr(4'h1, 8'hD5);
         chk_reg(area_active, 8'h2);
         u_fpc_cpu_model.lanes = 4'h2;
         wr(4'h0, 8'h00);
         u_fpc_cpu_model.lanes = 4'h1;
         rd(4'h0);
         chk_reg(q, 8'hE8);
         $display("key test done");
      end
   endtask
   task t_erase;
      begin
         u_fpc_cpu_model.place_vectors;
         wr(4'h8, 8'h1);
         rd(4'h8);
         chk_reg(q, 8'h01);
         wr(4'h6, 8'hAA);
         wr(4'h6, 8'h12);
         rd(4'h7);
         chk_reg(q, 8'h02);
         wr(4'h7, 8'h2);
         erase_seq;
         rd(4'h2);
         chk_pin(q[7], 1'b1);
         chk_pin(q[0], 1'b1);
         u_fpc_cpu_model.poll(q);
         chk_pin(q[7], 1'b0);
         chk_pin(irq, 1'b1);
         wr(4'h7, 8'h1);
         chk_pin(irq, 1'b0);
         wr(4'h0, 8'h40);
         wr(4'h1, 8'hD5);
         chk_pin(cmd_enabled, 1'b0);
         chk_reg(area_active, 8'h0);
         erase_seq;
         rd(4'h2);
         chk_pin(q[7], 1'b0);
         rd(4'h7);
         chk_reg(q, 8'h00);
         $display("erase test done");
      end
   endtask
   task t_page;
      begin
         wr(4'h0, 8'hA8);
         wr(4'h1, 8'hD5);
         wr(4'h8, 8'h0);
         wr(4'h6, 8'hAA);
         wr(4'h6, 8'h55);
         wr(4'h6, 8'hA0);
         for (n = 0; n < 128; n = n + 1) wr(4'h6, n[7:0]);
         rd(4'h2);
         chk_pin(q[7], 1'b1);
         chk_pin(q[0], 1'b0);
         u_fpc_cpu_model.poll(q);
         chk_reg(pulses, 8'h0);
         wr(4'h3, 8'h10);
         chk_reg(pulses, 8'h1);
         chk_pin(irq, 1'b0);
         rd(4'h7);
         chk_reg(q, 8'h1);
         $display("page test done");
      end
   endtask
   task t_ram;
      begin
         wr(4'h4, 8'h06);
         rd(4'h4);
         chk_reg(q, 8'h06);
         wr(4'h5, 8'h33);
         chk_pin(ram_on, 1'b0);
         wr(4'h5, 8'hD4);
         chk_pin(ram_on & vec_on, 1'b1);
         rd(4'h9);
         chk_reg(q, 8'h17);
         wr(4'h4, 8'h04);
         wr(4'h5, 8'hD4);
         chk_pin(ram_on & vec_on, 1'b1);
         wr(4'h4, 8'h00);
         wr(4'h5, 8'hD4);
         chk_pin(ram_on | vec_on, 1'b0);
         $display("mapping test done");
      end
   endtask
   task conclude;
      begin
         $display("compares %0d, mismatches %0d", compares, err_count);
         if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
         end else begin
            $display("Testbench failed");
         end
         $finish;
      end
   endtask
   initial begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_key;
      t_erase;
      t_page;
      t_ram;
      conclude;
   end
   initial begin
      #100000;
      err_count = err_count + 1;
      conclude;
   end
endmodule // tb_top
